//--- hw/bbr_pkg.sv
// bbr_pkg: address map, sizes and states of the bit-band alias remapper
// assumes a 32-bit little-endian byte-addressed memory bus
package bbr_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam logic [31:0] SRAM_BB_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_BB_LAST = 32'h2000_1fff;
  localparam logic [31:0] SRAM_AL_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_AL_LAST = 32'h2203_ffff;
  localparam logic [31:0] PERI_BB_BASE = 32'h4000_0000;
  localparam logic [31:0] PERI_BB_LAST = 32'h400f_ffff;
  localparam logic [31:0] PERI_AL_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_AL_LAST = 32'h43ff_ffff;
  // alias offset = byte index * 32 + bit * 4
  localparam int unsigned BYTE_SHIFT = 5;
  localparam int unsigned BIT_LSB = 2;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned BYTE_IDX_W = 20;
  // access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [31:0] ALIAS_ONE = 32'h0000_0001;
  localparam logic [31:0] ALIAS_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {ST_IDLE, ST_PASS, ST_RD, ST_WR, ST_RESP} bbr_state_t;
endpackage

//--- hw/bbr_alias_decode.sv
// bbr_alias_decode: checks one alias window and inverts the alias formula
// assumes the window base is aligned to its size
`timescale 1ns/10ps
module bbr_alias_decode
  import bbr_pkg::*;
#(
  parameter logic [31:0] AL_BASE = 32'h0000_0000,
  parameter logic [31:0] AL_LAST = 32'h0000_0000,
  parameter logic [31:0] BB_BASE = 32'h0000_0000
) (
  // request address
  input wire logic [31:0] addr,
  // decode result
  output logic hit,
  output logic [31:0] byte_addr,
  output logic [2:0] bit_sel
);
  logic [31:0] offs;
  assign offs = addr - AL_BASE;
  assign hit = (addr >= AL_BASE) && (addr <= AL_LAST);
  // a window that reaches past its bit-band region would alias unrelated memory
  if (AL_LAST < AL_BASE || ((AL_LAST - AL_BASE) >> BYTE_SHIFT) >= (32'h1 << BYTE_IDX_W)) begin : g_bad_window
    $error("alias window does not fit its bit-band region");
  end
  // byte index from offset/32, bit from offset[4:2]
  assign byte_addr = BB_BASE + {5'h00, offs[31:BYTE_SHIFT]};
  assign bit_sel = offs[BIT_LSB +: BIT_W];
endmodule

//--- hw/bbr_lane_sel.sv
// bbr_lane_sel: picks the target bit out of a read word and builds the rmw word
// little-endian: byte n of a word sits on lanes [8n+7:8n]
`timescale 1ns/10ps
module bbr_lane_sel
  import bbr_pkg::*;
(
  // target position
  input wire logic [1:0] byte_lane,
  input wire logic [2:0] bit_sel,
  // data
  input wire logic [31:0] rd_word,
  input wire logic new_bit,
  // results
  output logic cur_bit,
  output logic [31:0] wr_word
);
  logic [4:0] pos;
  assign pos = {byte_lane, bit_sel};
  assign cur_bit = rd_word[pos];
  always_comb begin
    wr_word = rd_word;
    wr_word[pos] = new_bit;
  end
endmodule

//--- hw/bbr_remap.sv
// bbr_remap: bit-band alias remapper between core load/store port and memory bus
// assumes a simple valid/ready request bus upstream and a request/ack bus downstream,
// one outstanding transfer each side; down_rdata is valid with down_ack
//
// Behaviour
// - each alias word maps to one bit
// - bit-band regions sit at bottom 1 MB; the SRAM region here spans only the bottom 8 KB
// - SRAM bit-band range accessed directly as SRAM
// - SRAM alias data remapped, fetches not remapped
// - peripheral bit-band range accessed directly
// - peripheral alias data remapped, fetches refused
// - alias write is read, modify, write back
// - offset is byte times 32 plus bit times 4
// - alias address is base plus offset, inverted
// - underlying access keeps incoming access size
// - write data bit 0 sets or clears bit
// - write data bits 31:1 are ignored
// - alias read returns zero or one
// - little-endian byte order selects target byte
`timescale 1ns/10ps
module bbr_remap
  import bbr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // upstream request from the core
  input wire logic up_valid,
  input wire logic up_write,
  input wire logic up_fetch,
  input wire logic [1:0] up_size,
  input wire logic [31:0] up_addr,
  input wire logic [31:0] up_wdata,
  // upstream answer
  output logic up_ready,
  output logic up_done,
  output logic up_err,
  output logic [31:0] up_rdata,
  // downstream bus
  output logic down_req,
  output logic down_write,
  output logic down_fetch,
  output logic [1:0] down_size,
  output logic [31:0] down_addr,
  output logic [31:0] down_wdata,
  input wire logic down_ack,
  input wire logic down_err,
  input wire logic [31:0] down_rdata
);
  typedef struct packed {
    bbr_state_t st;
    logic ready;
    logic done;
    logic err;
    logic [31:0] rdata;
    logic req;
    logic write;
    logic fetch;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic alias_op;
    logic wb;
    logic new_bit;
    logic [2:0] bit_sel;
  } bbr_regs_t;

  bbr_regs_t s_reg;
  bbr_regs_t s_next;

  logic sram_hit, peri_hit;
  logic [31:0] sram_baddr, peri_baddr;
  logic [2:0] sram_bit, peri_bit;
  logic cur_bit;
  logic [31:0] rmw_word;
  logic [31:0] bus_word;

  bbr_alias_decode #(
    .AL_BASE(SRAM_AL_BASE),
    .AL_LAST(SRAM_AL_LAST),
    .BB_BASE(SRAM_BB_BASE)
  ) u_sram_dec (
    .addr(up_addr),
    .hit(sram_hit),
    .byte_addr(sram_baddr),
    .bit_sel(sram_bit)
  );

  bbr_alias_decode #(
    .AL_BASE(PERI_AL_BASE),
    .AL_LAST(PERI_AL_LAST),
    .BB_BASE(PERI_BB_BASE)
  ) u_peri_dec (
    .addr(up_addr),
    .hit(peri_hit),
    .byte_addr(peri_baddr),
    .bit_sel(peri_bit)
  );

  // byte lanes are fixed by the underlying address; data sits on its own lanes
  assign bus_word = down_rdata;

  bbr_lane_sel u_lane (
    .byte_lane(s_reg.addr[1:0]),
    .bit_sel(s_reg.bit_sel),
    .rd_word(bus_word),
    .new_bit(s_reg.new_bit),
    .cur_bit(cur_bit),
    .wr_word(rmw_word)
  );

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.ready = 1'b1;
        s_next.err = 1'b0;
        if (up_valid && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.size = up_size;
          s_next.fetch = up_fetch;
          if (peri_hit && up_fetch) begin
            // execution from the peripheral alias is refused, no bus cycle
            s_next.err = 1'b1;
            s_next.rdata = ALIAS_ZERO;
            s_next.done = 1'b1;
            s_next.st = ST_RESP;
          end else if ((sram_hit || peri_hit) && !up_fetch) begin
            s_next.alias_op = 1'b1;
            s_next.addr = sram_hit ? sram_baddr : peri_baddr;
            s_next.bit_sel = sram_hit ? sram_bit : peri_bit;
            s_next.new_bit = up_wdata[0];
            s_next.write = 1'b0;
            s_next.req = 1'b1;
            s_next.st = ST_RD;
          end else begin
            // includes direct bit-band range accesses and sram alias fetches
            s_next.alias_op = 1'b0;
            s_next.addr = up_addr;
            s_next.write = up_write;
            s_next.wdata = up_wdata;
            s_next.req = 1'b1;
            s_next.st = ST_PASS;
          end
          s_next.wdata = s_next.alias_op ? ALIAS_ZERO : up_wdata;
          if (s_next.alias_op) begin
            s_next.write = 1'b0;
          end
          // the write-back need is kept apart from the bus strobes, so the read half
          // of the rmw goes out as a plain read and down_fetch stays a bare flop
          s_next.wb = s_next.alias_op && up_write;
          s_next.fetch = up_fetch;
        end
      end
      ST_PASS: begin
        if (down_ack) begin
          s_next.req = 1'b0;
          s_next.rdata = down_rdata;
          s_next.err = down_err;
          s_next.done = 1'b1;
          s_next.st = ST_RESP;
        end
      end
      ST_RD: begin
        if (down_ack) begin
          s_next.req = 1'b0;
          s_next.rdata = cur_bit ? ALIAS_ONE : ALIAS_ZERO;
          s_next.err = down_err;
          // a failed read is never followed by a write of stale data
          if (s_reg.wb && !down_err) begin
            s_next.wdata = rmw_word;
            s_next.write = 1'b1;
            s_next.req = 1'b1;
            s_next.st = ST_WR;
          end else begin
            s_next.done = 1'b1;
            s_next.st = ST_RESP;
          end
        end
      end
      ST_WR: begin
        if (down_ack) begin
          s_next.req = 1'b0;
          s_next.write = 1'b0;
          s_next.err = down_err;
          s_next.rdata = ALIAS_ZERO;
          s_next.done = 1'b1;
          s_next.st = ST_RESP;
        end
      end
      ST_RESP: begin
        s_next.ready = 1'b1;
        s_next.alias_op = 1'b0;
        s_next.wb = 1'b0;
        s_next.fetch = 1'b0;
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign up_ready = s_reg.ready;
  assign up_done = s_reg.done;
  assign up_err = s_reg.err;
  assign up_rdata = s_reg.rdata;
  assign down_req = s_reg.req;
  assign down_write = s_reg.write;
  assign down_fetch = s_reg.fetch;
  assign down_size = s_reg.size;
  assign down_addr = s_reg.addr;
  assign down_wdata = s_reg.wdata;

  // assertions
  // an alias access is followed step by step: take, read, optional write back, answer
  sequence alias_take_s;
    up_valid && up_ready && !up_fetch && (sram_hit || peri_hit);
  endsequence
  sequence read_first_s;
    down_req && !down_write && s_reg.alias_op;
  endsequence
  sequence rmw_read_s;
    s_reg.st == ST_RD && down_ack && s_reg.wb && !down_err;
  endsequence
  sequence rmw_write_s;
    down_req && down_write && s_reg.st == ST_WR;
  endsequence
  sequence read_last_s;
    s_reg.st == ST_RD && down_ack && (!s_reg.wb || down_err);
  endsequence
  sequence answer_s;
    up_done && !down_req;
  endsequence

  // read-modify-write order
  a_alias_reads_first: assert property (@(posedge clock) disable iff (!nrst)
    alias_take_s |=> read_first_s) else $error("alias access did not start with a read");
  a_rmw_write_follows: assert property (@(posedge clock) disable iff (!nrst)
    rmw_read_s |=> rmw_write_s) else $error("alias write did not write back");
  a_read_ends: assert property (@(posedge clock) disable iff (!nrst)
    read_last_s |=> answer_s) else $error("alias read or aborted write did not end");
  a_write_back_ends: assert property (@(posedge clock) disable iff (!nrst)
    s_reg.st == ST_WR && down_ack |=> up_done && !down_req && !down_write)
    else $error("write back did not end");
  a_wb_same_target: assert property (@(posedge clock) disable iff (!nrst)
    rmw_read_s |=> down_size == $past(down_size) && down_addr == $past(down_addr))
    else $error("write back went elsewhere");

  // bit values on the way out and back
  a_bit_set_clear: assert property (@(posedge clock) disable iff (!nrst)
    rmw_read_s |=> down_wdata[{down_addr[1:0], s_reg.bit_sel}] == s_reg.new_bit) else $error("bad target bit");
  a_other_bits_kept: assert property (@(posedge clock) disable iff (!nrst)
    rmw_read_s |=> (down_wdata | (32'h1 << {down_addr[1:0], s_reg.bit_sel}))
      == ($past(down_rdata) | (32'h1 << {down_addr[1:0], s_reg.bit_sel}))) else $error("rmw disturbed bits");
  a_alias_read_value: assert property (@(posedge clock) disable iff (!nrst)
    up_done && s_reg.alias_op && !s_reg.wb |-> up_rdata[31:1] == 31'h0) else $error("alias read not 0/1");
  a_read_bit_value: assert property (@(posedge clock) disable iff (!nrst)
    s_reg.st == ST_RD && down_ack |=> up_rdata == {31'h0, $past(down_rdata[{s_reg.addr[1:0], s_reg.bit_sel}])})
    else $error("alias read value wrong");

  // address decoding
  a_sram_alias_map: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && !up_fetch && sram_hit |=>
      down_addr == SRAM_BB_BASE + (($past(up_addr) - SRAM_AL_BASE) >> BYTE_SHIFT)
      && s_reg.bit_sel == $past(up_addr[BIT_LSB +: BIT_W])) else $error("sram map");
  a_peri_alias_map: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && !up_fetch && peri_hit |=>
      down_addr == PERI_BB_BASE + (($past(up_addr) - PERI_AL_BASE) >> BYTE_SHIFT)
      && s_reg.bit_sel == $past(up_addr[BIT_LSB +: BIT_W])) else $error("peripheral map");
  a_sram_fetch_direct: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && up_fetch && sram_hit |=>
      down_req && down_fetch && !s_reg.alias_op && down_addr == $past(up_addr)) else $error("sram fetch remapped");
  a_peri_fetch_err: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && up_fetch && peri_hit |=>
      up_done && up_err && !down_req && up_rdata == ALIAS_ZERO) else $error("fetch not refused");
  a_direct_bb: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && ((up_addr >= SRAM_BB_BASE && up_addr <= SRAM_BB_LAST)
      || (up_addr >= PERI_BB_BASE && up_addr <= PERI_BB_LAST)) |=>
      down_req && !s_reg.alias_op && down_addr == $past(up_addr) && down_write == $past(up_write))
    else $error("direct bit-band access altered");
  a_pass_through: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && !sram_hit && !peri_hit |=>
      down_addr == $past(up_addr) && down_wdata == $past(up_wdata) && !s_reg.alias_op) else $error("pass");
  a_pass_answer: assert property (@(posedge clock) disable iff (!nrst)
    s_reg.st == ST_PASS && down_ack |=> up_done && !down_req && up_rdata == $past(down_rdata))
    else $error("pass answer");

  // downstream request issued with the incoming size and held steady until it is answered
  a_size_kept: assert property (@(posedge clock) disable iff (!nrst)
    up_valid && up_ready && !(up_fetch && peri_hit) |=> down_req && down_size == $past(up_size)) else $error("size");
  a_req_held: assert property (@(posedge clock) disable iff (!nrst)
    down_req && !down_ack |=> down_req && $stable(down_addr) && $stable(down_size) && $stable(down_write)
      && $stable(down_wdata)) else $error("request changed before ack");
endmodule

//--- sim/bbr_mem_model.sv
// bbr_mem_model: downstream memory answering the req/ack bus
// assumes one request at a time, held until its ack
`timescale 1ns/10ps
module bbr_mem_model
  import bbr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request
  input wire logic down_req,
  input wire logic down_write,
  input wire logic [1:0] down_size,
  input wire logic [31:0] down_addr,
  input wire logic [31:0] down_wdata,
  // bench controls
  input wire logic [3:0] wait_cyc,
  input wire logic fail_read,
  // answer
  output logic down_ack,
  output logic down_err,
  output logic [31:0] down_rdata
);
  logic [31:0] mem [logic [29:0]];
  logic [3:0] cnt;
  logic [3:0] be;
  logic [31:0] w;
  always_comb begin
    case (down_size)
      SZ_BYTE: be = 4'h1 << down_addr[1:0];
      SZ_HALF: be = 4'h3 << {down_addr[1], 1'b0};
      default: be = 4'hf;
    endcase
  end
  // read data toggles outside the ack cycle so a stale sample never matches
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      down_ack <= 1'b0;
      down_err <= 1'b0;
      down_rdata <= 32'h0;
      cnt <= 4'h0;
    end else if (!down_ack && down_req && cnt == wait_cyc) begin
      cnt <= 4'h0;
      down_ack <= 1'b1;
      down_err <= fail_read && !down_write;
      w = mem.exists(down_addr[31:2]) ? mem[down_addr[31:2]] : 32'h0;
      down_rdata <= w;
      for (int i = 0; i < 4; i++) begin
        if (be[i]) w[8*i +: 8] = down_wdata[8*i +: 8];
      end
      if (down_write) mem[down_addr[31:2]] = w;
    end else begin
      if (!down_ack && down_req) cnt <= cnt + 4'h1;
      down_ack <= 1'b0;
      down_err <= 1'b0;
      down_rdata <= ~down_rdata;
    end
  end
endmodule

//--- sim/bbr_remap_bench.sv
// bbr_remap_bench: self-checking bench for bbr_remap
// assumes bbr_mem_model stands on the downstream bus
`timescale 1ns/10ps
module bbr_remap_bench;
  import bbr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic up_valid = 1'b0, up_write = 1'b0, up_fetch = 1'b0;
  logic [1:0] up_size = 2'h0;
  logic [31:0] up_addr = 32'h0, up_wdata = 32'h0;
  logic up_ready, up_done, up_err, down_req, down_write, down_fetch, down_ack, down_err;
  logic [1:0] down_size, last_sz;
  logic [31:0] up_rdata, down_addr, down_wdata, down_rdata, last_a;
  logic [3:0] wait_cyc = 4'h0;
  logic fail_read = 1'b0;
  logic last_f;
  int n_down = 0, cyc = 0, err_total = 0, n_checks = 0;
  localparam logic [31:0] AL[5] = '{32'h2200_0000, 32'h2200_001c, 32'h2203_fffc, 32'h43ff_ffe0, 32'h4200_0134};
  localparam logic [31:0] BA[5] = '{32'h2000_0000, 32'h2000_0000, 32'h2000_1fff, 32'h400f_ffff, 32'h4000_0009};
  localparam logic [2:0] BI[5] = '{3'h0, 3'h7, 3'h7, 3'h0, 3'h5};
  bbr_remap u_dut (.clock, .nrst, .up_valid, .up_write, .up_fetch, .up_size, .up_addr, .up_wdata, .up_ready,
    .up_done, .up_err, .up_rdata, .down_req, .down_write, .down_fetch, .down_size, .down_addr, .down_wdata,
    .down_ack, .down_err, .down_rdata);
  bbr_mem_model u_mem (.clock, .nrst, .down_req, .down_write, .down_size, .down_addr, .down_wdata,
    .wait_cyc, .fail_read, .down_ack, .down_err, .down_rdata);
  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (down_req && down_ack) begin
      n_down <= n_down + 1;
      last_a <= down_addr;
      last_sz <= down_size;
      last_f <= down_fetch;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one core access; entered and left at a falling edge
  task automatic acc(input logic wr, fe, input logic [1:0] sz, input logic [31:0] a, d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    up_valid = 1'b1;
    up_write = wr;
    up_fetch = fe;
    up_size = sz;
    up_addr = a;
    up_wdata = d;
    while (up_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    up_valid = 1'b0;
    while (up_done !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("up_done", 32'h1, {31'h0, up_done});
    rd = up_rdata;
    er = up_err;
    @(negedge clock);
  endtask
  task automatic t_pass();
    logic [31:0] rd;
    logic er;
    acc(1'b1, 1'b0, SZ_WORD, 32'h2000_0004, 32'hdead_beef, rd, er);
    chk("pass addr", 32'h2000_0004, last_a);
    chk("pass err", 32'h0, {31'h0, er});
    chk("pass fetch flag", 32'h0, {31'h0, last_f});
    acc(1'b0, 1'b0, SZ_WORD, 32'h2000_0004, 32'h0, rd, er);
    chk("pass rdata", 32'hdead_beef, rd);
    acc(1'b1, 1'b0, SZ_BYTE, 32'h4000_0013, 32'h5a00_0000, rd, er);
    chk("pass size", {30'h0, SZ_BYTE}, {30'h0, last_sz});
    chk("pass lane", 32'h5a00_0000, u_mem.mem[30'h1000_0004]);
    acc(1'b0, 1'b0, SZ_WORD, 32'h2204_0000, 32'h0, rd, er);
    chk("above window", 32'h2204_0000, last_a);
  endtask
  task automatic t_alias();
    logic [31:0] rd, pre, m;
    logic er;
    int n0;
    for (int k = 0; k < 5; k++) begin
      wait_cyc = 4'(k);
      m = 32'h1 << {BA[k][1:0], BI[k]};
      // target bit starts clear so that a missed set shows
      pre = 32'h3c3c_c3c3 & ~m;
      u_mem.mem[BA[k][31:2]] = pre;
      n0 = n_down;
      acc(1'b1, 1'b0, 2'(k % 3), AL[k], 32'hff, rd, er);
      chk("rmw count", 32'h2, 32'(n_down - n0));
      chk("rmw addr", BA[k], last_a);
      chk("rmw size", 32'(k % 3), {30'h0, last_sz});
      chk("set bit", pre | m, u_mem.mem[BA[k][31:2]]);
      acc(1'b0, 1'b0, SZ_WORD, AL[k], 32'h0, rd, er);
      chk("read one", ALIAS_ONE, rd);
      acc(1'b1, 1'b0, 2'(k % 3), AL[k], 32'he, rd, er);
      chk("clear bit", pre & ~m, u_mem.mem[BA[k][31:2]]);
      acc(1'b0, 1'b0, SZ_WORD, AL[k], 32'h0, rd, er);
      chk("read zero", ALIAS_ZERO, rd);
    end
    wait_cyc = 4'h0;
  endtask
  task automatic t_fetch_err();
    logic [31:0] rd;
    logic er;
    int n0;
    n0 = n_down;
    acc(1'b0, 1'b1, SZ_WORD, 32'h4200_0000, 32'h0, rd, er);
    chk("fetch err", 32'h1, {31'h0, er});
    chk("fetch bus", 32'h0, 32'(n_down - n0));
    chk("fetch rdata", ALIAS_ZERO, rd);
    acc(1'b0, 1'b1, SZ_WORD, 32'h2200_0040, 32'h0, rd, er);
    chk("fetch addr", 32'h2200_0040, last_a);
    chk("fetch kept", 32'h1, {31'h0, last_f});
    fail_read = 1'b1;
    u_mem.mem[30'h0800_0000] = 32'h0;
    n0 = n_down;
    acc(1'b1, 1'b0, SZ_WORD, 32'h2200_0000, 32'h1, rd, er);
    fail_read = 1'b0;
    chk("abort err", 32'h1, {31'h0, er});
    chk("abort count", 32'h1, 32'(n_down - n0));
    chk("abort mem", 32'h0, u_mem.mem[30'h0800_0000]);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    t_pass();
    t_alias();
    t_fetch_err();
    finish_test();
  end
endmodule
